// [src/dhbil_pkg.sv]
// dhbil_pkg: register map, field positions, reset values and codes
// assumes a 32-bit apb slave with word-aligned registers
package dhbil_pkg;

    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] DHBIL_CMD_OFS    = 8'h00;
    localparam logic [7:0] DHBIL_OVR_OFS    = 8'h04;
    localparam logic [7:0] DHBIL_SEL_OFS    = 8'h08;
    localparam logic [7:0] DHBIL_CTL_OFS    = 8'h0c;
    localparam logic [7:0] DHBIL_STAT_OFS   = 8'h10;

    // ------------------------------------------------------------
    // command register: unlock field
    // ------------------------------------------------------------
    localparam int         DHBIL_LOCK_LSB   = 0;
    localparam int         DHBIL_LOCK_W     = 2;
    localparam logic [1:0] DHBIL_UNLOCK_KEY = 2'h2;
    localparam logic [1:0] DHBIL_LOCK_KEY   = 2'h1;

    // ------------------------------------------------------------
    // override register fields
    // ------------------------------------------------------------
    localparam int DHBIL_OVR_DIS1   = 0;
    localparam int DHBIL_OVR_DIS2   = 1;
    localparam int DHBIL_OVR_IN1    = 2;
    localparam int DHBIL_OVR_IN2    = 3;
    localparam logic [3:0] DHBIL_OVR_RST = 4'h0;

    // ------------------------------------------------------------
    // combine select register fields
    // ------------------------------------------------------------
    localparam int DHBIL_SEL_DIS    = 0;
    localparam int DHBIL_SEL_IN1    = 1;
    localparam int DHBIL_SEL_IN2    = 2;
    localparam logic [2:0] DHBIL_SEL_RST = 3'h0;

    // ------------------------------------------------------------
    // control register fields
    // ------------------------------------------------------------
    localparam int DHBIL_CTL_TRIPEN = 0;
    localparam int DHBIL_CTL_EARLY  = 1;
    localparam logic [1:0] DHBIL_CTL_RST = 2'h0;

    // ------------------------------------------------------------
    // trip force-low time
    // ------------------------------------------------------------
    localparam int DHBIL_CLK_MHZ    = 100;
    localparam int DHBIL_TRIP_NS    = 1000;
    localparam int DHBIL_TRIP_CYC   = (DHBIL_TRIP_NS * DHBIL_CLK_MHZ + 999) / 1000;

    // per-bridge output drive states
    typedef enum logic [1:0]
    {
        DHBIL_OUT_HIZ  = 2'b00,
        DHBIL_OUT_LOW  = 2'b01,
        DHBIL_OUT_HIGH = 2'b10
    } dhbil_out_e;

endpackage : dhbil_pkg

// [src/dhbil_core.sv]
// dhbil_core: independent-mode two half-bridge input logic with apb registers
// assumes pins come from outside pclk domain; trip and open-load comparators outside
//
// Contract
// R01: two half-bridges controlled independently
// R02: sleep low forces both hi-z, no sense
// R03: disable high gives standby, no sense
// R04: active output follows input; sense from high outputs
// R05: trip forces high output low fixed time
// R06: only high-side sourced current is sensed
// R07: sense is sum of both bridges
// R08: active open-load check only for high-driven outputs
// R09: pin variant: one disable covers both bridges
// R10: register variant: two disables, two inputs
// R11: override bits honoured only after unlock code
// R12: select 0 combines pin OR bit
// R13: select 1 combines pin AND bit
// R14: bridge2 disable uses shared pin with bit2
// R15: disabled bridge hi-z, other stays active
// R16: early option: unlocked uses register bits only
// R17: locked uses pins directly
// R18: select and override changes act immediately
//
// Decided for this implementation: the register offsets and register access over APB.
`timescale 1ns/1ns
module dhbil_core
    import dhbil_pkg::*;
#(
    parameter int TRIP_CYC = DHBIL_TRIP_CYC
)
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        sleep_bar_pin,
    input  wire logic        output_disable_pin,
    input  wire logic        bridge1_input_pin,
    input  wire logic        bridge2_input_pin,
    input  wire logic        trip_level_reached,
    output logic [1:0]       half_bridge1_output,
    output logic [1:0]       half_bridge2_output,
    output logic             bridge1_sense_current,
    output logic             bridge2_sense_current,
    output logic [1:0]       sense_current_output,
    output logic [1:0]       active_open_load_check,
    output logic             device_active
);

    if (TRIP_CYC < 1 || TRIP_CYC > 65535)
        $error("dhbil_core: TRIP_CYC out of range");

    // ------------------------------------------------------------
    // pin synchronisers: three stages, change once stages 2,3 agree
    // ------------------------------------------------------------
    logic [3:0] s1_r, s2_r, s3_r, pin_r;
    logic [3:0] s1_nxt, s2_nxt, s3_nxt, pin_nxt;
    logic       trip1_r, trip2_r, trip3_r, trip_r;
    logic       trip1_nxt, trip2_nxt, trip3_nxt, trip_nxt;

    always_comb
    begin
        s1_nxt  = {sleep_bar_pin, output_disable_pin, bridge2_input_pin, bridge1_input_pin};
        s2_nxt  = s1_r;
        s3_nxt  = s2_r;
        pin_nxt = pin_r;
        for (int i = 0; i < 4; i++)
        begin
            if (s2_r[i] == s3_r[i])
                pin_nxt[i] = s3_r[i];
        end
        trip1_nxt = trip_level_reached;
        trip2_nxt = trip1_r;
        trip3_nxt = trip2_r;
        trip_nxt  = (trip2_r == trip3_r) ? trip3_r : trip_r;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s1_r    <= 4'h4;
            s2_r    <= 4'h4;
            s3_r    <= 4'h4;
            pin_r   <= 4'h4;
            trip1_r <= 1'b0;
            trip2_r <= 1'b0;
            trip3_r <= 1'b0;
            trip_r  <= 1'b0;
        end
        else
        begin
            s1_r    <= s1_nxt;
            s2_r    <= s2_nxt;
            s3_r    <= s3_nxt;
            pin_r   <= pin_nxt;
            trip1_r <= trip1_nxt;
            trip2_r <= trip2_nxt;
            trip3_r <= trip3_nxt;
            trip_r  <= trip_nxt;
        end
    end

    logic in1_pin, in2_pin, dis_pin, sleep_n;
    assign in1_pin = pin_r[0];
    assign in2_pin = pin_r[1];
    assign dis_pin = pin_r[2];
    assign sleep_n = pin_r[3];

    // ------------------------------------------------------------
    // apb registers
    // ------------------------------------------------------------
    logic       unlock_r, unlock_nxt;
    logic [3:0] ovr_r, ovr_nxt;
    logic [2:0] sel_r, sel_nxt;
    logic [1:0] ctl_r, ctl_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic       wr_en, rd_en, hit;
    logic [31:0] stat_w;

    assign wr_en   = psel && penable && pwrite;
    assign rd_en   = psel && !penable && !pwrite;
    assign pready  = 1'b1;
    assign hit     = (paddr == DHBIL_CMD_OFS) || (paddr == DHBIL_OVR_OFS)
                  || (paddr == DHBIL_SEL_OFS) || (paddr == DHBIL_CTL_OFS)
                  || (paddr == DHBIL_STAT_OFS);
    assign pslverr = psel && penable && !hit;
    assign prdata  = rdata_r;

    always_comb
    begin
        unlock_nxt = unlock_r;
        ovr_nxt    = ovr_r;
        sel_nxt    = sel_r;
        ctl_nxt    = ctl_r;
        rdata_nxt  = rdata_r;
        if (wr_en)
        begin
            unique case (paddr)
                DHBIL_CMD_OFS:
                begin
                    if (pwdata[DHBIL_LOCK_LSB +: DHBIL_LOCK_W] == DHBIL_UNLOCK_KEY)
                        unlock_nxt = 1'b1;                                     // [R11]
                    else if (pwdata[DHBIL_LOCK_LSB +: DHBIL_LOCK_W] == DHBIL_LOCK_KEY)
                        unlock_nxt = 1'b0;
                end
                DHBIL_OVR_OFS:  ovr_nxt = pwdata[3:0];                         // [R10]
                DHBIL_SEL_OFS:  sel_nxt = pwdata[2:0];                         // [R18]
                DHBIL_CTL_OFS:  ctl_nxt = pwdata[1:0];
                default:        ;
            endcase
        end
        if (rd_en)
        begin
            unique case (paddr)
                DHBIL_CMD_OFS:  rdata_nxt = {31'h0, unlock_r};
                DHBIL_OVR_OFS:  rdata_nxt = {28'h0, ovr_r};
                DHBIL_SEL_OFS:  rdata_nxt = {29'h0, sel_r};
                DHBIL_CTL_OFS:  rdata_nxt = {30'h0, ctl_r};
                DHBIL_STAT_OFS: rdata_nxt = stat_w;
                default:        rdata_nxt = 32'h0;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            unlock_r <= 1'b0;
            ovr_r    <= DHBIL_OVR_RST;
            sel_r    <= DHBIL_SEL_RST;
            ctl_r    <= DHBIL_CTL_RST;
            rdata_r  <= 32'h0;
        end
        else
        begin
            unlock_r <= unlock_nxt;
            ovr_r    <= ovr_nxt;
            sel_r    <= sel_nxt;
            ctl_r    <= ctl_nxt;
            rdata_r  <= rdata_nxt;
        end
    end

    // ------------------------------------------------------------
    // combined inputs
    // ------------------------------------------------------------
    function automatic logic dhbil_comb(input logic pin, input logic bit_v, input logic sel);
        dhbil_comb = sel ? (pin & bit_v) : (pin | bit_v);                      // [R12] [R13]
    endfunction : dhbil_comb

    logic dis1_c, dis2_c, in1_c, in2_c;

    always_comb
    begin
        if (!unlock_r)
        begin
            dis1_c = dis_pin;                                                  // [R09] [R17]
            dis2_c = dis_pin;
            in1_c  = in1_pin;
            in2_c  = in2_pin;
        end
        else if (ctl_r[DHBIL_CTL_EARLY])
        begin
            dis1_c = ovr_r[DHBIL_OVR_DIS1];                                    // [R16]
            dis2_c = ovr_r[DHBIL_OVR_DIS2];
            in1_c  = ovr_r[DHBIL_OVR_IN1];
            in2_c  = ovr_r[DHBIL_OVR_IN2];
        end
        else
        begin
            dis1_c = dhbil_comb(dis_pin, ovr_r[DHBIL_OVR_DIS1], sel_r[DHBIL_SEL_DIS]);
            dis2_c = dhbil_comb(dis_pin, ovr_r[DHBIL_OVR_DIS2], sel_r[DHBIL_SEL_DIS]); // [R14]
            in1_c  = dhbil_comb(in1_pin, ovr_r[DHBIL_OVR_IN1], sel_r[DHBIL_SEL_IN1]);
            in2_c  = dhbil_comb(in2_pin, ovr_r[DHBIL_OVR_IN2], sel_r[DHBIL_SEL_IN2]);
        end
    end

    // ------------------------------------------------------------
    // trip force-low timer
    // ------------------------------------------------------------
    logic [15:0] trip_cnt_r, trip_cnt_nxt;
    logic        trip_on;

    assign trip_on = (trip_cnt_r != 16'h0);

    always_comb
    begin
        trip_cnt_nxt = trip_cnt_r;
        if (trip_on)
            trip_cnt_nxt = trip_cnt_r - 16'h1;
        else if (ctl_r[DHBIL_CTL_TRIPEN] && trip_r && (bridge1_sense_current
                 || bridge2_sense_current))
            trip_cnt_nxt = 16'(TRIP_CYC);                                      // [R05] [R07]
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            trip_cnt_r <= 16'h0;
        else
            trip_cnt_r <= trip_cnt_nxt;
    end

    // ------------------------------------------------------------
    // output decode, registered
    // ------------------------------------------------------------
    logic [1:0] o1_r, o1_nxt, o2_r, o2_nxt;

    function automatic logic [1:0] dhbil_drive(input logic dis, input logic in, input logic trip);
        if (dis)
            dhbil_drive = DHBIL_OUT_HIZ;                                       // [R15]
        else if (in && !trip)
            dhbil_drive = DHBIL_OUT_HIGH;                                      // [R04]
        else
            dhbil_drive = DHBIL_OUT_LOW;                                       // [R05]
    endfunction : dhbil_drive

    always_comb
    begin
        if (!sleep_n)
        begin
            o1_nxt = DHBIL_OUT_HIZ;                                            // [R02]
            o2_nxt = DHBIL_OUT_HIZ;
        end
        else if (dis1_c && dis2_c)
        begin
            o1_nxt = DHBIL_OUT_HIZ;                                            // [R03]
            o2_nxt = DHBIL_OUT_HIZ;
        end
        else
        begin
            o1_nxt = dhbil_drive(dis1_c, in1_c, trip_on);                      // [R01]
            o2_nxt = dhbil_drive(dis2_c, in2_c, trip_on);
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            o1_r <= DHBIL_OUT_HIZ;
            o2_r <= DHBIL_OUT_HIZ;
        end
        else
        begin
            o1_r <= o1_nxt;
            o2_r <= o2_nxt;
        end
    end

    assign half_bridge1_output    = o1_r;
    assign half_bridge2_output    = o2_r;
    assign bridge1_sense_current  = (o1_r == DHBIL_OUT_HIGH);                  // [R06]
    assign bridge2_sense_current  = (o2_r == DHBIL_OUT_HIGH);
    assign sense_current_output   = 2'(bridge1_sense_current) + 2'(bridge2_sense_current); // [R07]
    assign active_open_load_check = {bridge2_sense_current, bridge1_sense_current}; // [R08]
    assign device_active          = (o1_r != DHBIL_OUT_HIZ) || (o2_r != DHBIL_OUT_HIZ);

    assign stat_w = {19'h0, trip_on, pin_r, o2_r, o1_r, dis2_c, dis1_c, in2_c, in1_c};

endmodule : dhbil_core

// [verif/dhbil_core_asserts.sv]
// dhbil_core_asserts: output relation checks for dhbil_core
// assumes it is bound to the dhbil_core ports
`timescale 1ns/1ns
module dhbil_core_asserts
    import dhbil_pkg::*;
(
    input wire logic       pclk,
    input wire logic       presetn,
    input wire logic       sleep_bar_pin,
    input wire logic [1:0] half_bridge1_output,
    input wire logic [1:0] half_bridge2_output,
    input wire logic       bridge1_sense_current,
    input wire logic       bridge2_sense_current,
    input wire logic [1:0] sense_current_output,
    input wire logic [1:0] active_open_load_check,
    input wire logic       device_active
);
    // ----
    // checks
    // ----
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire logic h1 = (half_bridge1_output == DHBIL_OUT_HIGH);
    wire logic h2 = (half_bridge2_output == DHBIL_OUT_HIGH);
    a_sense_one: assert property (bridge1_sense_current == h1)
        else $error("bridge1 sense wrong");
    a_sense_two: assert property (bridge2_sense_current == h2)
        else $error("bridge2 sense wrong");
    a_sense_sum: assert property (sense_current_output ==
        {1'b0, bridge1_sense_current} + {1'b0, bridge2_sense_current})
        else $error("sense sum wrong");
    a_olc_high: assert property (active_open_load_check == {h2, h1})
        else $error("open load check wrong");
    a_sleep_hiz: assert property (!sleep_bar_pin [*7] |->
        half_bridge1_output == DHBIL_OUT_HIZ && half_bridge2_output == DHBIL_OUT_HIZ)
        else $error("sleep not hi-z");
    a_sleep_quiet: assert property (!sleep_bar_pin [*7] |-> sense_current_output == 2'h0)
        else $error("sense in sleep");
    a_active_flag: assert property (device_active ==
        (half_bridge1_output != DHBIL_OUT_HIZ || half_bridge2_output != DHBIL_OUT_HIZ))
        else $error("active flag wrong");
    a_out_legal: assert property (half_bridge1_output != 2'h3 &&
        half_bridge2_output != 2'h3)
        else $error("illegal output code");
endmodule : dhbil_core_asserts

bind dhbil_core dhbil_core_asserts i_chk (.pclk, .presetn, .sleep_bar_pin,
    .half_bridge1_output, .half_bridge2_output, .bridge1_sense_current,
    .bridge2_sense_current, .sense_current_output, .active_open_load_check,
    .device_active);

// [verif/dhbil_host.sv]
// dhbil_host: host model driving apb and control pins
// assumes a zero or multi wait apb slave on pclk
`timescale 1ns/1ns
module dhbil_host
(
    input  wire logic        pclk,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr,
    output logic             psel = 1'b0,
    output logic             penable = 1'b0,
    output logic             pwrite = 1'b0,
    output logic      [7:0]  paddr = 8'h00,
    output logic      [31:0] pwdata = 32'h0,
    output logic             sleep_bar_pin = 1'b0,
    output logic             output_disable_pin = 1'b1,
    output logic             bridge1_input_pin = 1'b0,
    output logic             bridge2_input_pin = 1'b0,
    output logic             trip_level_reached = 1'b0
);
    // ----
    // apb transfer, held until pready
    // ----
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
              output logic [31:0] q, output logic e);
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        pwdata  <= ~d;
    endtask : xfer

    task pins(input logic s, input logic d, input logic a, input logic b);
        @(posedge pclk);
        sleep_bar_pin      <= s;
        output_disable_pin <= d;
        bridge1_input_pin  <= a;
        bridge2_input_pin  <= b;
    endtask : pins

    task trip(input logic t);
        @(posedge pclk);
        trip_level_reached <= t;
    endtask : trip
endmodule : dhbil_host

// [verif/dhbil_core_tb_top.sv]
// dhbil_core_tb_top: self-checking bench for dhbil_core
// assumes dhbil_host as the host and the bound checker
`timescale 1ns/1ns
module dhbil_core_tb_top;
    import dhbil_pkg::*;
    logic pclk = 1'b0, presetn = 1'b0, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, q;
    logic        sl, dis, i1, i2, trp, s1, s2, act, e;
    logic [1:0]  o1, o2, sns, olc;
    int          num_errors = 0;
    int          cmp_count = 0;
    localparam logic [1:0] Z = DHBIL_OUT_HIZ, L = DHBIL_OUT_LOW, H = DHBIL_OUT_HIGH;

    always #5 pclk = ~pclk;

    dhbil_host i_host (.pclk, .prdata, .pready, .pslverr, .psel, .penable, .pwrite,
        .paddr, .pwdata, .sleep_bar_pin(sl), .output_disable_pin(dis),
        .bridge1_input_pin(i1), .bridge2_input_pin(i2), .trip_level_reached(trp));
    dhbil_core #(.TRIP_CYC(20)) i_dut (.pclk, .presetn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .sleep_bar_pin(sl),
        .output_disable_pin(dis), .bridge1_input_pin(i1), .bridge2_input_pin(i2),
        .trip_level_reached(trp), .half_bridge1_output(o1), .half_bridge2_output(o2),
        .bridge1_sense_current(s1), .bridge2_sense_current(s2),
        .sense_current_output(sns), .active_open_load_check(olc), .device_active(act));

    // ----
    // helpers
    // ----
    task chk(input string n, input logic [31:0] x, input logic [31:0] g);
        cmp_count++;
        if (g !== x)
        begin
            num_errors++;
            $display("unexpected %s expected %h seen %h", n, x, g);
        end
    endtask : chk

    task outs(input logic [1:0] x1, input logic [1:0] x2, input logic [1:0] xs);
        repeat (8) @(posedge pclk);
        #1;
        chk("half_bridge1_output", {30'h0, x1}, {30'h0, o1});
        chk("half_bridge2_output", {30'h0, x2}, {30'h0, o2});
        chk("sense", {30'h0, xs}, {30'h0, sns});
        chk("sense bits", {30'h0, x2 == H, x1 == H}, {30'h0, s2, s1});
        chk("olc", {30'h0, x2 == H, x1 == H}, {30'h0, olc});
        chk("active", {31'h0, x1 != Z || x2 != Z}, {31'h0, act});
    endtask : outs

    task wr(input logic [7:0] a, input logic [31:0] d);
        i_host.xfer(1'b1, a, d, q, e);
    endtask : wr

    // ----
    // scenarios
    // ----
    task t_regs();
        i_host.xfer(1'b0, DHBIL_OVR_OFS, 32'h0, q, e);
        chk("ovr", 32'h0, q);
        i_host.xfer(1'b0, DHBIL_SEL_OFS, 32'h0, q, e);
        chk("sel", 32'h0, q);
        i_host.xfer(1'b0, 8'h20, 32'h0, q, e);
        chk("unmapped err", 32'h1, {31'h0, e});
    endtask : t_regs

    task t_pins();
        i_host.pins(1'b0, 1'b0, 1'b1, 1'b1);
        outs(Z, Z, 2'h0);
        i_host.pins(1'b1, 1'b1, 1'b1, 1'b1);
        outs(Z, Z, 2'h0);
        for (int i = 0; i < 4; i++)
        begin
            i_host.pins(1'b1, 1'b0, i[0], i[1]);
            outs(i[0] ? H : L, i[1] ? H : L, 2'(i[0]) + 2'(i[1]));
        end
        i_host.xfer(1'b0, DHBIL_STAT_OFS, 32'h0, q, e);
        chk("stat", 32'h0ba3, q);
    endtask : t_pins

    task t_ovr();
        wr(DHBIL_CMD_OFS, 32'h2);
        i_host.xfer(1'b0, DHBIL_CMD_OFS, 32'h0, q, e);
        chk("unlock", 32'h1, q);
        wr(DHBIL_OVR_OFS, 32'h2);
        outs(H, Z, 2'h1);
        wr(DHBIL_SEL_OFS, 32'h1);
        wr(DHBIL_OVR_OFS, 32'h1);
        i_host.pins(1'b1, 1'b1, 1'b1, 1'b1);
        outs(Z, H, 2'h1);
        wr(DHBIL_SEL_OFS, 32'h0);
        i_host.pins(1'b1, 1'b0, 1'b0, 1'b0);
        wr(DHBIL_OVR_OFS, 32'h4);
        outs(H, L, 2'h1);
        wr(DHBIL_CMD_OFS, 32'h1);
        outs(L, L, 2'h0);
    endtask : t_ovr

    task t_early();
        wr(DHBIL_CTL_OFS, 32'h2);
        wr(DHBIL_CMD_OFS, 32'h2);
        wr(DHBIL_OVR_OFS, 32'h8);
        i_host.pins(1'b1, 1'b1, 1'b1, 1'b0);
        outs(L, H, 2'h1);
        wr(DHBIL_CMD_OFS, 32'h1);
        outs(Z, Z, 2'h0);
        wr(DHBIL_CTL_OFS, 32'h0);
    endtask : t_early

    task t_trip();
        wr(DHBIL_CTL_OFS, 32'h1);
        i_host.pins(1'b1, 1'b0, 1'b1, 1'b0);
        outs(H, L, 2'h1);
        i_host.trip(1'b1);
        repeat (8) @(posedge pclk);
        #1;
        chk("trip half_bridge1_output", {30'h0, L}, {30'h0, o1});
        i_host.trip(1'b0);
        repeat (10) @(posedge pclk);
        #1;
        chk("hold half_bridge1_output", {30'h0, L}, {30'h0, o1});
        repeat (30) @(posedge pclk);
        #1;
        chk("rearm half_bridge1_output", {30'h0, H}, {30'h0, o1});
    endtask : t_trip

    task final_report();
        if (num_errors == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : final_report

    initial
    begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_pins();
        t_ovr();
        t_early();
        t_trip();
        final_report();
    end

    initial
    begin
        #200000;
        num_errors++;
        final_report();
    end
endmodule : dhbil_core_tb_top
